// ===== logic/ppom_top.sv
/*
 Per-port power control and overcurrent sense for the downstream ports of a hub,
 with a classic Wishbone register slave. Assumes pin inputs already synchronous to clk_i
 and an external resolver that builds each pin level from pin_o and pin_oe_o.
*/
module ppom_top #(
  parameter int MS_CYCLES = ppom_pkg::MS_CYCLES // Clock cycles per millisecond
) (
  input wire logic clk_i, // Core clock, 50 MHz
  input wire logic sys_rst_i, // Asynchronous reset, active high
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [15:0] wb_adr_i, // Wishbone byte address
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [ppom_pkg::NPORT-1:0] pin_i, // Sense level of each port pin
  output logic [ppom_pkg::NPORT-1:0] pin_o, // Driven level, always low
  output logic [ppom_pkg::NPORT-1:0] pin_oe_o, // High while the pin is driven low
  output logic [ppom_pkg::NPORT-1:0] pullup_en_o, // Pull-up enable per pin
  output logic [ppom_pkg::NPORT-1:0] split_en_o, // Port split enable per port
  output logic [ppom_pkg::NPORT-1:0] oc_flag_o // Latched overcurrent flags
);
  localparam int NP = ppom_pkg::NPORT;
  localparam int PW = $clog2(MS_CYCLES + 1);

  // ==========================================================
  // Register slave
  logic [7:0] lockout;
  logic [3:0] min_width;
  logic [7:0] dbl_window;
  logic [NP-1:0] power_ctrl;
  logic [NP-1:0] split_ctrl;
  logic gang;
  logic [NP-1:0] oc_flag;
  logic [NP-1:0] evt;

  wire [ppom_pkg::IDX_W-1:0] idx = wb_adr_i[15:2];
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire rd_status = req & ~wb_we_i & (idx == ppom_pkg::IDX_OC_STATUS);

  function automatic logic hit(input logic [ppom_pkg::IDX_W-1:0] a,
                               input logic [ppom_pkg::IDX_W-1:0] b);
    hit = (a == b);
  endfunction

  logic [31:0] rd_data;
  always_comb begin
    rd_data = '0;
    if (hit(idx, ppom_pkg::IDX_LOCKOUT)) rd_data[7:0] = lockout;
    if (hit(idx, ppom_pkg::IDX_MIN_WIDTH)) rd_data[3:0] = min_width;
    if (hit(idx, ppom_pkg::IDX_DBL_WINDOW)) rd_data[7:0] = dbl_window;
    if (hit(idx, ppom_pkg::IDX_POWER_CTRL)) rd_data[NP-1:0] = power_ctrl;
    if (hit(idx, ppom_pkg::IDX_OC_STATUS)) rd_data[NP-1:0] = oc_flag;
    if (hit(idx, ppom_pkg::IDX_MODE_CFG)) rd_data[ppom_pkg::MODE_GANG_BIT] = gang;
    if (hit(idx, ppom_pkg::IDX_SPLIT_CTRL)) rd_data[NP-1:0] = split_ctrl;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rd_data : '0;
    end
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      lockout <= ppom_pkg::RST_LOCKOUT;
      min_width <= ppom_pkg::RST_MIN_WIDTH;
      dbl_window <= ppom_pkg::RST_DBL_WINDOW;
      power_ctrl <= '0;
      split_ctrl <= '0;
      gang <= 1'b0;
    end else if (wr) begin
      if (hit(idx, ppom_pkg::IDX_LOCKOUT)) lockout <= wb_dat_i[7:0];
      if (hit(idx, ppom_pkg::IDX_MIN_WIDTH)) min_width <= wb_dat_i[3:0];
      if (hit(idx, ppom_pkg::IDX_DBL_WINDOW)) dbl_window <= wb_dat_i[7:0];
      if (hit(idx, ppom_pkg::IDX_POWER_CTRL)) power_ctrl <= wb_dat_i[NP-1:0];
      if (hit(idx, ppom_pkg::IDX_MODE_CFG)) gang <= wb_dat_i[ppom_pkg::MODE_GANG_BIT];
      if (hit(idx, ppom_pkg::IDX_SPLIT_CTRL)) split_ctrl <= wb_dat_i[NP-1:0];
    end
  end

  // ==========================================================
  // Thresholds
  // Codes above 5 ms are undefined; clamp so the count never overflows
  wire [3:0] min_eff = (min_width > ppom_pkg::MIN_WIDTH_MAX) ? ppom_pkg::MIN_WIDTH_MAX
                                                             : min_width;
  wire [ppom_pkg::LOW_W-1:0] low_thr = ppom_pkg::LOW_W'(int'(min_eff) * MS_CYCLES);
  wire [PW-1:0] ms_last = PW'(MS_CYCLES - 1);
  wire any_evt = |evt;

  // ==========================================================
  // Per-port monitor
  logic [NP-1:0] pwr_eff;
  logic [NP-1:0] pwr_q;
  logic [NP-1:0] smp;
  logic [NP-1:0] prev_low;
  logic [NP-1:0] win_act;
  logic [NP-1:0] armed;
  logic [NP-1:0] low;
  logic [NP-1:0] lock_done;

  genvar p;
  generate
    for (p = 0; p < NP; p++) begin : g_port
      logic [PW-1:0] presc;
      logic [7:0] lock_ms;
      logic [7:0] win_ms;
      logic [ppom_pkg::LOW_W-1:0] low_cyc;
      // Ganged mode: power control bit 0 is the shared power control for all ports
      wire pwr = gang ? power_ctrl[0] : power_ctrl[p];
      wire turn_on = pwr & ~pwr_q[p];
      wire tick = (presc == ms_last);
      wire fall = armed[p] & low[p] & ~prev_low[p];
      wire win_start = fall & ~win_act[p];
      wire single = armed[p] & low[p] & (low_cyc >= low_thr);
      wire double = fall & win_act[p];
      wire win_end = tick & (win_ms == dbl_window - 8'h01);
      wire set = evt[p] | (gang & any_evt);

      assign pwr_eff[p] = pwr;
      assign low[p] = pwr_q[p] & ~smp[p];
      assign lock_done[p] = (lock_ms >= lockout);
      assign armed[p] = pwr_q[p] & lock_done[p] & ~turn_on;
      assign evt[p] = single | double;

      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          pwr_q[p] <= 1'b0;
          smp[p] <= 1'b1;
          pin_oe_o[p] <= 1'b1;
          pullup_en_o[p] <= 1'b0;
        end else begin
          pwr_q[p] <= pwr;
          smp[p] <= pin_i[p];
          pin_oe_o[p] <= ~pwr;
          pullup_en_o[p] <= pwr;
        end
      end

      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          presc <= '0;
          lock_ms <= '0;
        end else if (~pwr | turn_on | win_start) begin
          presc <= '0;
          lock_ms <= (~pwr | turn_on) ? 8'h00 : lock_ms;
        end else begin
          presc <= tick ? '0 : presc + PW'(1);
          lock_ms <= (tick & ~lock_done[p]) ? lock_ms + 8'h01 : lock_ms;
        end
      end

      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          win_act[p] <= 1'b0;
          win_ms <= '0;
          prev_low[p] <= 1'b0;
          low_cyc <= '0;
        end else begin
          prev_low[p] <= armed[p] & low[p];
          low_cyc <= (armed[p] & low[p] & ~(&low_cyc)) ? low_cyc + 1'b1 :
                     (armed[p] & low[p]) ? low_cyc : '0;
          if (~armed[p] | double) begin
            win_act[p] <= 1'b0;
            win_ms <= '0;
          end else if (win_start) begin
            win_act[p] <= 1'b1;
            win_ms <= '0;
          end else if (win_act[p] & tick) begin
            win_act[p] <= ~win_end;
            win_ms <= win_ms + 8'h01;
          end
        end
      end

      // A new event in the read cycle wins over the read clear
      always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          oc_flag[p] <= 1'b0;
        end else begin
          oc_flag[p] <= set | (oc_flag[p] & ~rd_status);
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      split_en_o <= '0;
      oc_flag_o <= '0;
      pin_o <= '0;
    end else begin
      split_en_o <= split_ctrl;
      oc_flag_o <= oc_flag;
      pin_o <= '0;
    end
  end

  // ==========================================================
  // Checks
  sequence s_on_edge;
    pwr_eff[0] & ~pwr_q[0];
  endsequence

  property p_drive_low_off;
    @(posedge clk_i) disable iff (sys_rst_i)
      ~pwr_eff[0] |=> pin_oe_o[0] & ~pullup_en_o[0] & ~pin_o[0];
  endproperty
  a_drive_low_off: assert property (p_drive_low_off) else $error("Off port not driven low");

  property p_release_on;
    @(posedge clk_i) disable iff (sys_rst_i)
      pwr_eff[0] |=> ~pin_oe_o[0] & pullup_en_o[0];
  endproperty
  a_release_on: assert property (p_release_on) else $error("On port not released");

  property p_lockout;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_on_edge |=> ~evt[0] [*2];
  endproperty
  a_lockout: assert property (p_lockout) else $error("Event during lockout");

  property p_timer_restart;
    @(posedge clk_i) disable iff (sys_rst_i)
      s_on_edge |=> (g_port[0].lock_ms == 8'h00) & (g_port[0].presc == '0) & ~win_act[0];
  endproperty
  a_timer_restart: assert property (p_timer_restart) else $error("Timers not restarted");

  property p_gang_all;
    @(posedge clk_i) disable iff (sys_rst_i)
      gang & any_evt |=> &oc_flag;
  endproperty
  a_gang_all: assert property (p_gang_all) else $error("Ganged event not on all ports");

  property p_single;
    @(posedge clk_i) disable iff (sys_rst_i)
      armed[0] & low[0] & (g_port[0].low_cyc >= low_thr) |=> oc_flag[0] ##1 oc_flag_o[0];
  endproperty
  a_single: assert property (p_single) else $error("Long low not flagged");

  property p_double;
    @(posedge clk_i) disable iff (sys_rst_i)
      win_act[0] & armed[0] & low[0] & ~prev_low[0] |=> oc_flag[0] & ~win_act[0];
  endproperty
  a_double: assert property (p_double) else $error("Second low group not flagged");

  property p_read_clear;
    @(posedge clk_i) disable iff (sys_rst_i)
      rd_status & ~evt[0] & ~(gang & any_evt) |=> ~oc_flag[0];
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("Flag not cleared by read");

  property p_reset_values;
    @(posedge clk_i) sys_rst_i |-> (min_width == ppom_pkg::RST_MIN_WIDTH) &
      (dbl_window == ppom_pkg::RST_DBL_WINDOW) & (lockout == ppom_pkg::RST_LOCKOUT) & ~gang;
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("Bad reset value");

  property p_width_read;
    @(posedge clk_i) disable iff (sys_rst_i)
      req & ~wb_we_i & hit(idx, ppom_pkg::IDX_MIN_WIDTH) |=> wb_ack_o & (wb_dat_o[31:4] == '0);
  endproperty
  a_width_read: assert property (p_width_read) else $error("Reserved width bits set");
endmodule

// ===== logic/ppom_pkg.sv
/*
 Constants for the port power and overcurrent monitor: register indices, reset values,
 field layout and timing. Assumes a 50 MHz core clock and a 32-bit Wishbone bus.
*/
// Operation
// - Sample each powered port's shared control and sense pin every clock.
// - Flag overcurrent when the pin stays low for the single-pulse minimum width.
// - Flag overcurrent when two low groups start within the double-pulse window.
// - Ignore the pin for the lockout time right after port power turns on.
// - Minimum width uses bits 3:0, codes 0 to 5 ms; upper bits read zero.
// - Minimum width resets to the 5 ms code.
// - Double-pulse window is eight bits, one millisecond per count.
// - Double-pulse window resets to 20 ms.
// - Lockout is eight bits in milliseconds; events inside it are discarded.
// - Lockout resets to 10 ms.
// - Power off: drive the pin low with the pull-up disabled.
// - Power on: release the driver and enable the pull-up, open drain.
// - A low pin from an opened poly fuse counts as overcurrent.
// - Port split lets a port's USB 2.0 and USB 3 PHYs run independently.
// - Ganged mode flags every port when any port reports overcurrent.
// - Individual power control is the reset mode; ganged only by configuration.
package ppom_pkg;
  localparam int NPORT = 6;
  localparam int IDX_W = 14;
  localparam int LOW_W = 18;
  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LOCKOUT = 14'h30E1;
  localparam logic [IDX_W-1:0] IDX_MIN_WIDTH = 14'h30EA;
  localparam logic [IDX_W-1:0] IDX_DBL_WINDOW = 14'h30EB;
  localparam logic [IDX_W-1:0] IDX_POWER_CTRL = 14'h30F0;
  localparam logic [IDX_W-1:0] IDX_OC_STATUS = 14'h30F1;
  localparam logic [IDX_W-1:0] IDX_MODE_CFG = 14'h30F2;
  localparam logic [IDX_W-1:0] IDX_SPLIT_CTRL = 14'h30F3;
  localparam logic [7:0] RST_LOCKOUT = 8'h0A;
  localparam logic [3:0] RST_MIN_WIDTH = 4'h5;
  localparam logic [7:0] RST_DBL_WINDOW = 8'h14;
  localparam logic [3:0] MIN_WIDTH_MAX = 4'h5;
  localparam int MIN_WIDTH_W = 4;
  localparam int MODE_GANG_BIT = 0;
  localparam int MS_TIME_NS = 1000000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_CYCLES = MS_TIME_NS / CLK_PERIOD_NS;
endpackage

// ===== dv/ppom_switch_model.sv
/*
 Behavioural power switch beside each port pin of the monitor.
 Assumes one fault request per port from the bench and a pull-up that the monitor enables.
*/
module ppom_switch_model (
  input wire logic clk_i, // Core clock
  input wire logic [ppom_pkg::NPORT-1:0] drv_i, // Driven pin level
  input wire logic [ppom_pkg::NPORT-1:0] oe_i, // Pin driver enable
  input wire logic [ppom_pkg::NPORT-1:0] pullup_i, // Pull-up enable
  input wire logic [ppom_pkg::NPORT-1:0] fault_i, // Switch reports overcurrent
  output logic [ppom_pkg::NPORT-1:0] pin_o // Resolved pin level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic toggle = 1'b0;
  always @(posedge clk_i) toggle <= ~toggle;
  // A floating pin moves every cycle so that no settled value can pass for a level
  always_comb begin
    for (int p = 0; p < ppom_pkg::NPORT; p++) begin
      if (oe_i[p]) pin_o[p] = drv_i[p];
      // Fuse path has no power-good delay, as the zero descriptor values expect
      else if (fault_i[p]) pin_o[p] = 1'b0;
      else if (pullup_i[p]) pin_o[p] = 1'b1;
      else pin_o[p] = toggle ^ p[0];
    end
  end
endmodule

// ===== dv/ppom_tb_top.sv
/*
 Self-checking bench for the port power monitor: Wishbone master, expected-read queue.
 Assumes the switch model resolves every pin and a short millisecond parameter.
*/
module ppom_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MS = 20;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [15:0] wb_adr_i = 16'h0000;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic wb_ack_o;
  logic [5:0] pin_i, pin_o, pin_oe_o, pullup_en_o, split_en_o, oc_flag_o, m;
  logic [5:0] fault = 6'h00;
  logic [31:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  int p;
  always #10 clk_i = ~clk_i;
  ppom_top #(.MS_CYCLES(MS)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pin_i(pin_i),
    .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pullup_en_o(pullup_en_o),
    .split_en_o(split_en_o), .oc_flag_o(oc_flag_o));
  ppom_switch_model model (.clk_i(clk_i), .drv_i(pin_o), .oe_i(pin_oe_o),
    .pullup_i(pullup_en_o), .fault_i(fault), .pin_o(pin_i));
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [13:0] idx, input logic [31:0] d,
                    input logic [31:0] e);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    if (!we) exp_q.push_back(e);
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic low_for(input logic [5:0] f, input int n);
    @(posedge clk_i);
    fault <= f;
    repeat (n) @(posedge clk_i);
    fault <= 6'h00;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // ==========================================================
  // Read answers are judged against the oldest note
  always @(posedge clk_i)
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, exp_q.pop_front());
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    end_sim();
  end
  initial begin
    // Raised in the scheduled region so the reset edge is seen by every flop
    sys_rst_i <= 1'b1;
    p = $urandom(32'h3929C4A5);
    repeat (16) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    settle(1);
    check(pin_oe_o, 32'h3F);
    check(pullup_en_o, 32'h00);
    check(pin_o, 32'h00);
    check(split_en_o, 32'h00);
    wb(1'b0, ppom_pkg::IDX_LOCKOUT, 32'h0, 32'h0A);
    wb(1'b0, ppom_pkg::IDX_MIN_WIDTH, 32'h0, 32'h05);
    wb(1'b0, ppom_pkg::IDX_DBL_WINDOW, 32'h0, 32'h14);
    wb(1'b0, 14'h0123, 32'h0, 32'h0);
    wb(1'b1, ppom_pkg::IDX_MIN_WIDTH, 32'hFF, 32'h0);
    wb(1'b0, ppom_pkg::IDX_MIN_WIDTH, 32'h0, 32'h0F);
    $display("test reset_values done");
    // Lockout of 3 ms, then a 2 ms single pulse
    m = 6'h01 << $urandom_range(5, 0);
    wb(1'b1, ppom_pkg::IDX_MIN_WIDTH, 32'h2, 32'h0);
    wb(1'b1, ppom_pkg::IDX_LOCKOUT, 32'h3, 32'h0);
    wb(1'b1, ppom_pkg::IDX_POWER_CTRL, {26'h0, m}, 32'h0);
    settle(1);
    check(pullup_en_o, {26'h0, m});
    check(pin_oe_o, {26'h0, ~m});
    low_for(m, 45);
    settle(20);
    check(oc_flag_o, 32'h0);
    low_for(m, 30);
    settle(2);
    check(oc_flag_o, 32'h0);
    // Let the window opened by that group run out, so only the width can flag
    settle(440);
    low_for(m, 45);
    settle(2);
    check(oc_flag_o, {26'h0, m});
    wb(1'b0, ppom_pkg::IDX_OC_STATUS, 32'h0, {26'h0, m});
    wb(1'b0, ppom_pkg::IDX_OC_STATUS, 32'h0, 32'h0);
    wb(1'b1, ppom_pkg::IDX_POWER_CTRL, 32'h0, 32'h0);
    settle(1);
    check(pin_oe_o, 32'h3F);
    $display("test single_pulse done");
    // Two short groups inside the window, each far below the single width
    wb(1'b1, ppom_pkg::IDX_MIN_WIDTH, 32'h5, 32'h0);
    wb(1'b1, ppom_pkg::IDX_POWER_CTRL, {26'h0, m}, 32'h0);
    settle(70);
    low_for(m, 5);
    settle(10);
    check(oc_flag_o, 32'h0);
    low_for(m, 5);
    settle(4);
    check(oc_flag_o, {26'h0, m});
    wb(1'b0, ppom_pkg::IDX_OC_STATUS, 32'h0, {26'h0, m});
    wb(1'b1, ppom_pkg::IDX_POWER_CTRL, 32'h0, 32'h0);
    $display("test double_pulse done");
    // Ganged power: one faulty port flags them all
    wb(1'b1, ppom_pkg::IDX_MODE_CFG, 32'h1, 32'h0);
    wb(1'b1, ppom_pkg::IDX_POWER_CTRL, 32'h1, 32'h0);
    settle(1);
    check(pullup_en_o, 32'h3F);
    settle(70);
    low_for(6'h01 << $urandom_range(5, 0), 110);
    settle(3);
    check(oc_flag_o, 32'h3F);
    $display("test ganged done");
    wb(1'b1, ppom_pkg::IDX_SPLIT_CTRL, 32'h2A, 32'h0);
    settle(1);
    check(split_en_o, 32'h2A);
    wb(1'b0, ppom_pkg::IDX_SPLIT_CTRL, 32'h0, 32'h2A);
    check(pin_o, 32'h00);
    $display("test split done");
    end_sim();
  end
endmodule
